// File: verilog/prom_prog_pkg.sv
`default_nettype none
package prom_prog_pkg;

    // memory organisation
    localparam int ADDR_W = 9;    // nine address lines
    localparam int WORD_W = 8;    // eight data outputs
    localparam int WORDS  = 512;  // addressable words

    // clock rate
    localparam int CLK_HZ  = 50_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;

    // free running timebase, period in milliseconds
    localparam int OSC_PERIOD_MS = 10;
    localparam int TICK_CYCLES   = OSC_PERIOD_MS * (CLK_HZ / 1000);

    // fuse pulse width limits, in microseconds
    localparam int PULSE_MIN_US     = 180;
    localparam int PULSE_MAX_US     = 50_000;
    // least time rounds up, longest rounds down
    localparam int PULSE_MIN_CYCLES = (PULSE_MIN_US * CLK_MHZ + 0) / 1;
    localparam int PULSE_MAX_CYCLES = PULSE_MAX_US * CLK_MHZ;

    // recommended duty cycle of the fuse pulse, percent
    localparam int DUTY_PCT = 20;

    // start button must stay stable this long, in microseconds
    localparam int DEBOUNCE_US     = 1000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;

    // pulse phase counter: preset value and the five working phases
    localparam logic [2:0] PHASE_PRESET = 3'h5;
    localparam logic [2:0] PH_SETTLE    = 3'h0;
    localparam logic [2:0] PH_PULSE     = 3'h1;
    localparam logic [2:0] PH_COOL      = 3'h2;
    localparam logic [2:0] PH_VERIFY    = 3'h3;
    localparam logic [2:0] PH_RELEASE   = 3'h4;

    // bit counter: preset, last value, offset to the bit index
    localparam logic [3:0] BIT_PRESET = 4'h4;
    localparam logic [3:0] BIT_LAST   = 4'hB;

    // select pins in order low_a, low_b, high_a, high_b
    localparam logic [3:0] SEL_ON  = 4'h3;
    localparam logic [3:0] SEL_OFF = 4'hB;

    // value driven onto a pin while it carries the fuse pulse
    localparam logic FUSE_PULSE_LEVEL = 1'b1;

    // pins that address and select the memory
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              select_low_a;
        logic              select_low_b;
        logic              select_high_a;
        logic              select_high_b;
    } prom_pins_type;

    // sequencer states
    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } state_type;

endpackage : prom_prog_pkg
`default_nettype wire

// File: verilog/start_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module start_debounce #(
    parameter int STABLE_CYCLES = 50000
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // raw button and clean press
    input  wire logic raw,
    output logic      press
);

    logic        stable_ff;  // accepted button level
    logic [31:0] count_ff;   // cycles the raw level has differed
    logic        press_ff;   // one cycle on an accepted rising edge

    // accept a new level only after it has held long enough;
    // a bounce restarts the count, so chatter never reaches the core
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stable_ff <= 1'b0;
            count_ff  <= 32'h0000_0000;
            press_ff  <= 1'b0;
        end else begin
            press_ff <= 1'b0;
            if (raw == stable_ff) begin
                count_ff <= 32'h0000_0000;
            end else if (count_ff == 32'(STABLE_CYCLES - 1)) begin
                stable_ff <= raw;
                count_ff  <= 32'h0000_0000;
                press_ff  <= raw;
            end else begin
                count_ff <= count_ff + 32'h0000_0001;
            end
        end
    end

    assign press = press_ff;

endmodule : start_debounce
`default_nettype wire

// File: verilog/prom_fuse_programmer.sv
// Functional notes
// (R1) memory holds 512 words, nine-bit address
// (R2) outputs enabled only when fully selected
// (R3) outputs three-state or open-collector by variant
// (R4) stored word appears within access time
// (R5) unprogrammed bit reads 1, programmed 0
// (R6) set address, then deselect the chip
// (R7) pulse one output, others left open
// (R8) pulse between 0.18 and 50 ms
// (R9) pulse duty cycle about 20 percent
// (R10) remove pulse, select chip, check 0
// (R11) step bits, each qualified by pattern
// (R12) idle display lit for 1 or deselected
// (R13) timing from free-running 10 ms tick
// (R14) press sets run, deselects the memory
// (R15) idle presets phase 5, bit 4
// (R16) bit advances on phase 3 to 4
// (R17) after last bit, preset and stop
// (R18) address and selects stable during pulse
`timescale 1ns/1ps
`default_nettype none
module prom_fuse_programmer #(
    parameter int TICK_CYCLES     = prom_prog_pkg::TICK_CYCLES,
    parameter int DEBOUNCE_CYCLES = prom_prog_pkg::DEBOUNCE_CYCLES
) (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    // operator switches and button
    input  wire logic [prom_prog_pkg::ADDR_W-1:0] addr_switch,
    input  wire logic [prom_prog_pkg::WORD_W-1:0] pattern_switch,
    input  wire logic                        start_button,
    // operator indicators
    output logic [prom_prog_pkg::WORD_W-1:0] display,
    output logic                             busy,
    output logic                             done,
    output logic                             verify_fail,
    // memory address and select pins
    output prom_prog_pkg::prom_pins_type     prom_pins,
    // memory data pins, split into three signals
    input  wire logic [prom_prog_pkg::WORD_W-1:0] data_in,
    output logic [prom_prog_pkg::WORD_W-1:0] data_out,
    output logic [prom_prog_pkg::WORD_W-1:0] data_oe
);

    // sequencer state
    prom_prog_pkg::state_type state_ff;
    // free running timebase
    logic [31:0] tick_cnt_ff;
    logic        tick;
    // pulse phase and bit counters
    logic [2:0]  phase_ff;
    logic [3:0]  bit_cnt_ff;
    logic [2:0]  bit_idx;
    // word and pattern captured at start
    logic [prom_prog_pkg::ADDR_W-1:0] addr_ff;
    logic [prom_prog_pkg::WORD_W-1:0] pattern_ff;
    // pin registers
    prom_prog_pkg::prom_pins_type     pins_ff;
    logic [prom_prog_pkg::WORD_W-1:0] pulse_ff;
    // indicators
    logic [prom_prog_pkg::WORD_W-1:0] display_ff;
    logic        done_ff;
    logic        fail_ff;
    // clean button press
    logic        press;
    // decoded step events
    logic        run;
    logic        advance;
    logic        last_bit;
    logic        chip_selected;

    // button filter
    start_debounce #(
        .STABLE_CYCLES (DEBOUNCE_CYCLES)
    ) u_debounce (
        .ref_clk (ref_clk),
        .rst     (rst),
        .raw     (start_button),
        .press   (press)
    );

    // bit index counts from the bit counter's preset upward
    assign bit_idx  = 3'(bit_cnt_ff - prom_prog_pkg::BIT_PRESET);
    assign run      = (state_ff == prom_prog_pkg::ST_RUN);
    assign last_bit = (bit_cnt_ff == prom_prog_pkg::BIT_LAST);
    // a step is ended by the tick in the verify phase
    assign advance  = run && tick && (phase_ff == prom_prog_pkg::PH_VERIFY);
    // (R2) full select pattern; the selects are the pin word's low bits
    assign chip_selected = (pins_ff[3:0] == prom_prog_pkg::SEL_ON);

    // (R13) free running tick
    // the timebase never stops, so every phase after the preset is a whole period long
    always_ff @(posedge ref_clk) begin
        if (rst || tick) begin
            tick_cnt_ff <= 32'h0000_0000;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
        end
    end

    assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

    // (R14) run flag set
    // (R17) run flag cleared
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= prom_prog_pkg::ST_IDLE;
        end else begin
            case (state_ff)
                // a press is only taken while idle
                prom_prog_pkg::ST_IDLE: begin
                    if (press) begin
                        state_ff <= prom_prog_pkg::ST_RUN;
                    end
                end
                // stop once the last bit has been verified
                prom_prog_pkg::ST_RUN: begin
                    if (advance && last_bit) begin
                        state_ff <= prom_prog_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= prom_prog_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // (R15) idle counter presets
    // (R16) bit step on 3 to 4
    always_ff @(posedge ref_clk) begin
        if (rst || !run || (advance && last_bit)) begin
            // presets while idle, and back to them at the end of the word
            phase_ff   <= prom_prog_pkg::PHASE_PRESET;
            bit_cnt_ff <= prom_prog_pkg::BIT_PRESET;
        end else if (advance) begin
            phase_ff   <= prom_prog_pkg::PH_RELEASE;
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end else if (tick) begin
            // preset and release both lead to a fresh settle phase
            if (phase_ff == prom_prog_pkg::PH_RELEASE ||
                phase_ff == prom_prog_pkg::PHASE_PRESET) begin
                phase_ff <= prom_prog_pkg::PH_SETTLE;
            end else begin
                phase_ff <= phase_ff + 3'h1;
            end
        end
    end

    // (R18) word held through run
    // address and pattern are latched at the press, so switch
    // movement during a sequence cannot disturb a pulse
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addr_ff    <= '0;
            pattern_ff <= '0;
        end else if (!run) begin
            addr_ff    <= addr_switch;
            pattern_ff <= pattern_switch;
        end
    end

    // (R6) address first, then deselect
    // (R10) select only to verify
    // (R12) idle keeps the chip selected
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pins_ff <= {prom_prog_pkg::ADDR_W'(0), prom_prog_pkg::SEL_OFF};
        end else if ((!run && !press) || (run && !advance &&
                     phase_ff == prom_prog_pkg::PH_VERIFY)) begin
            pins_ff <= {addr_ff, prom_prog_pkg::SEL_ON};
        end else begin
            // only one active-low select is raised to deselect
            pins_ff <= {addr_ff, prom_prog_pkg::SEL_OFF};
        end
    end

    // (R7) one pin pulsed
    // (R9) one phase in five
    // (R11) pattern qualifies the bit
    // (R8) one tick wide
    // the pulse lasts exactly one tick period; other pins float
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pulse_ff <= '0;
        end else if (run && tick && phase_ff == prom_prog_pkg::PH_SETTLE &&
                     pattern_ff[bit_idx]) begin
            pulse_ff <= prom_prog_pkg::WORD_W'(1) << bit_idx;
        end else if (tick) begin
            pulse_ff <= '0;
        end
    end

    assign data_oe  = pulse_ff;
    assign data_out = {prom_prog_pkg::WORD_W{prom_prog_pkg::FUSE_PULSE_LEVEL}}
                      & pulse_ff;

    // (R5) programmed bit must read 0
    // failure is sticky until the next press taken while idle; such a press
    // and a failure cannot meet, since failures only arise while running
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fail_ff <= 1'b0;
        end else if (advance && pattern_ff[bit_idx] && data_in[bit_idx]) begin
            fail_ff <= 1'b1;
        end else if (press && !run) begin
            fail_ff <= 1'b0;
        end
    end

    // end of sequence marker, one cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= advance && last_bit;
        end
    end

    // (R12) indicator per bit
    // a deselected chip floats high, so every lamp shows lit
    always_ff @(posedge ref_clk) begin
        if (rst || !chip_selected) begin
            display_ff <= '1;
        end else begin
            display_ff <= data_in;
        end
    end

    assign prom_pins   = pins_ff;
    assign display     = display_ff;
    assign busy        = run;
    assign done        = done_ff;
    assign verify_fail = fail_ff;

    // pulse length counter for the width check
    logic [31:0] pulse_len_ff;
    always_ff @(posedge ref_clk) begin
        if (rst || data_oe == '0) begin
            pulse_len_ff <= 32'h0000_0000;
        end else begin
            pulse_len_ff <= pulse_len_ff + 32'h0000_0001;
        end
    end

    // fuse pulse withdrawn
    sequence s_pulse_end;
        (data_oe != '0) ##1 (data_oe == '0);
    endsequence

    // verify phase of a run, before the tick that ends it
    sequence s_verify_window;
        run && (phase_ff == prom_prog_pkg::PH_VERIFY) && !advance;
    endsequence

    property p_one_pin;
        @(posedge ref_clk) disable iff (rst)
        $onehot0(data_oe);
    endproperty
    a_one_pin: assert property (p_one_pin) // (R7)
        else $error("more than one data pin pulsed");
    property p_deselect_in_pulse;
        @(posedge ref_clk) disable iff (rst)
        (data_oe != '0) |-> !chip_selected && pins_ff.select_low_a;
    endproperty
    a_deselect_in_pulse: assert property (p_deselect_in_pulse) // (R6)
        else $error("chip selected while pulse applied");
    property p_pulse_width;
        @(posedge ref_clk) disable iff (rst)
        s_pulse_end |-> ($past(pulse_len_ff, 1) == 32'(TICK_CYCLES - 1));
    endproperty
    a_pulse_width: assert property (p_pulse_width) // (R8)
        else $error("pulse width not one tick period");
    property p_pins_stable;
        @(posedge ref_clk) disable iff (rst)
        (data_oe != '0) && $past(data_oe != '0) |-> $stable(pins_ff);
    endproperty
    a_pins_stable: assert property (p_pins_stable) // (R18)
        else $error("address or selects moved during pulse");
    property p_verify_select;
        @(posedge ref_clk) disable iff (rst)
        s_verify_window |=> chip_selected && (data_oe == '0);
    endproperty
    a_verify_select: assert property (p_verify_select) // (R10)
        else $error("verify without full select or with pulse");
    property p_bit_step;
        @(posedge ref_clk) disable iff (rst)
        run && $changed(bit_cnt_ff) && $past(run)
            |-> $past(phase_ff) == prom_prog_pkg::PH_VERIFY;
    endproperty
    a_bit_step: assert property (p_bit_step) // (R16)
        else $error("bit counter moved outside phase 3 to 4");
    property p_idle_preset;
        @(posedge ref_clk) disable iff (rst)
        !run && $past(!run) |-> phase_ff == prom_prog_pkg::PHASE_PRESET
                                && bit_cnt_ff == prom_prog_pkg::BIT_PRESET;
    endproperty
    a_idle_preset: assert property (p_idle_preset) // (R15)
        else $error("counters not preset while idle");
    property p_press_runs;
        @(posedge ref_clk) disable iff (rst)
        press && !run |=> run ##1 !chip_selected;
    endproperty
    a_press_runs: assert property (p_press_runs) // (R14)
        else $error("press did not start a deselected run");
    property p_finish;
        @(posedge ref_clk) disable iff (rst)
        advance && last_bit |=> !run && done
            && phase_ff == prom_prog_pkg::PHASE_PRESET;
    endproperty
    a_finish: assert property (p_finish) // (R17)
        else $error("sequence did not end after last bit");
    property p_pattern_gate;
        @(posedge ref_clk) disable iff (rst)
        $rose(data_oe != '0) |-> pattern_ff[bit_idx]
            && data_oe[bit_idx] && phase_ff == prom_prog_pkg::PH_PULSE;
    endproperty
    a_pattern_gate: assert property (p_pattern_gate) // (R11)
        else $error("pulse on a bit the pattern does not ask for");
    property p_display;
        @(posedge ref_clk) disable iff (rst)
        ##1 (display == ($past(chip_selected) ? $past(data_in) : '1));
    endproperty
    a_display: assert property (p_display) // (R12)
        else $error("indicators do not follow the word");
    property p_tick_gap;
        @(posedge ref_clk) disable iff (rst)
        tick |=> !tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) // (R13)
        else $error("timebase ticks back to back");

endmodule : prom_fuse_programmer
`default_nettype wire

// File: tb/prom_model.sv
`timescale 1ns/1ps
`default_nettype none
module prom_model #(
    parameter int MIN_PULSE = 1  // pulse cycles that open a fuse
) (
    // clock
    input  wire logic                             ref_clk,
    // address and select pins
    input  wire prom_prog_pkg::prom_pins_type     pins,
    // programmer drive on the data pins
    input  wire logic [prom_prog_pkg::WORD_W-1:0] drv_out,
    input  wire logic [prom_prog_pkg::WORD_W-1:0] drv_oe,
    // fuses in these bits refuse to open
    input  wire logic [prom_prog_pkg::WORD_W-1:0] weak_bit,
    // resolved level of the data pins
    output logic [prom_prog_pkg::WORD_W-1:0]      data
);
    // fuse array, every bit fresh at one
    logic [prom_prog_pkg::WORD_W-1:0] mem [prom_prog_pkg::WORDS];
    logic                             sel;    // chip fully selected
    logic [prom_prog_pkg::WORD_W-1:0] lvl;    // pulse level per pin
    int                               width;  // cycles of current pulse

    initial begin
        foreach (mem[i]) mem[i] = '1;
        width = 0;
    end

    assign sel = !pins.select_low_a && !pins.select_low_b
                 && pins.select_high_a && pins.select_high_b;
    assign lvl = {prom_prog_pkg::WORD_W{prom_prog_pkg::FUSE_PULSE_LEVEL}};

    // open collector with pull-ups, word follows address at once
    always_comb begin
        for (int b = 0; b < prom_prog_pkg::WORD_W; b++) begin
            if (drv_oe[b]) begin
                data[b] = drv_out[b];
            end else if (sel) begin
                data[b] = mem[pins.addr][b];
            end else begin
                data[b] = 1'b1;  // pull-up while released
            end
        end
    end

    // only a long lone pulse on a deselected chip opens a fuse
    always @(posedge ref_clk) begin
        if (!sel && $onehot(drv_oe) && ((drv_out ^ lvl) & drv_oe) == '0) begin
            width <= width + 1;
            if (width + 1 >= MIN_PULSE && (drv_oe & weak_bit) == '0) begin
                mem[pins.addr] <= mem[pins.addr] & ~drv_oe;
            end
        end else begin
            width <= 0;
        end
    end
endmodule : prom_model
`default_nettype wire

// File: tb/prom_fuse_programmer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module prom_fuse_programmer_bench;
    localparam int TICK = 20;  // shortened timebase
    localparam int DEB  = 4;   // shortened debounce

    // design pins
    logic                         ref_clk = 1'b0;
    logic                         rst;
    logic                         start_button;
    logic [8:0]                   addr_switch;
    logic [7:0]                   pattern_switch;
    logic [7:0]                   display;
    logic                         busy;
    logic                         done;
    logic                         verify_fail;
    prom_prog_pkg::prom_pins_type prom_pins;
    prom_prog_pkg::prom_pins_type pins_q;  // pins one cycle ago
    logic [7:0]                   data_in;
    logic [7:0]                   data_out;
    logic [7:0]                   data_oe;
    logic [7:0]                   weak_bit;  // fuses that will not open
    // bookkeeping
    int err_total;
    int num_checks;
    int cyc;
    int width;
    int npulse;
    int ndone;
    int last_start;

    // ordinary runs: address, pattern, word read back afterwards
    typedef struct {
        logic [8:0] a;
        logic [7:0] p;
        logic [7:0] exp;
    } row_type;
    row_type rows [4] = '{'{9'h000, 8'h01, 8'hFE}, '{9'h1FF, 8'h80, 8'h7F},
                          '{9'h0A5, 8'hFF, 8'h00}, '{9'h000, 8'h02, 8'hFC}};

    prom_fuse_programmer #(.TICK_CYCLES(TICK), .DEBOUNCE_CYCLES(DEB)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .addr_switch(addr_switch),
        .pattern_switch(pattern_switch), .start_button(start_button),
        .display(display), .busy(busy), .done(done),
        .verify_fail(verify_fail), .prom_pins(prom_pins),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

    // pulse must last a full tick before a fuse gives way
    prom_model #(.MIN_PULSE(TICK)) i_prom (
        .ref_clk(ref_clk), .pins(prom_pins), .drv_out(data_out),
        .drv_oe(data_oe), .weak_bit(weak_bit), .data(data_in));

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic desel(input prom_prog_pkg::prom_pins_type p);
        return p.select_low_a | p.select_low_b
               | ~p.select_high_a | ~p.select_high_b;
    endfunction : desel

    task automatic chk_word(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : chk_flag

    task automatic chk_count(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            err_total++;
            $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask : chk_count

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    // button held for n cycles, released at a falling edge
    task automatic press(input int n);
        start_button = 1'b1;
        repeat (n) @(negedge ref_clk);
        start_button = 1'b0;
    endtask : press

    // one full run; bounded wait for done, then settle the display
    task automatic run_word(input logic [8:0] a, input logic [7:0] p);
        int n;
        @(negedge ref_clk);
        addr_switch = a;
        pattern_switch = p;
        npulse = 0;
        ndone = 0;
        press(DEB + 3);
        n = 0;
        while (ndone == 0 && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        repeat (4) @(negedge ref_clk);
        chk_count(ndone, 1);
        chk_flag(busy, 1'b0);
    endtask : run_word

    // pin watcher: sampled mid-cycle where outputs have settled
    always @(negedge ref_clk) begin
        cyc++;
        if (!rst) begin
            if (done === 1'b1) ndone++;
            if (data_oe !== 8'h00) begin
                chk_flag($onehot(data_oe), 1'b1);
                chk_word(data_out, data_oe);
                chk_flag(desel(prom_pins), 1'b1);
                chk_word(display, 8'hFF);
                if (width > 0) chk_flag(prom_pins === pins_q, 1'b1);
                if (width == 0) begin
                    // pulses of one run sit on a five-tick grid
                    if (last_start >= 0)
                        chk_count((cyc - last_start) % (5 * TICK), 0);
                    last_start = cyc;
                    npulse++;
                end
                width++;
            end else if (width > 0) begin
                chk_count(width, TICK);
                width = 0;
            end
            if (busy !== 1'b1) last_start = -1;
        end
        pins_q = prom_pins;
    end

    // watchdog: all runs together need well under 10000 cycles
    initial begin
        repeat (40000) @(posedge ref_clk);
        err_total++;
        end_sim();
    end

    initial begin
        rst = 1'b1;
        start_button = 1'b0;
        addr_switch = 9'h123;
        pattern_switch = 8'h00;
        weak_bit = 8'h00;
        err_total = 0;
        num_checks = 0;
        cyc = 0;
        width = 0;
        npulse = 0;
        ndone = 0;
        last_start = -1;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        // idle after reset: selected, fresh word shown, nothing driven
        chk_flag(busy, 1'b0);
        chk_flag(verify_fail, 1'b0);
        chk_flag(desel(prom_pins), 1'b0);
        chk_word(display, 8'hFF);
        chk_word(data_oe, 8'h00);
        chk_flag(prom_pins.addr === addr_switch, 1'b1);
        foreach (rows[i]) begin
            run_word(rows[i].a, rows[i].p);
            chk_count(npulse, $countones(rows[i].p));
            chk_word(display, rows[i].exp);
            chk_flag(verify_fail, 1'b0);
        end
        // a press shorter than the debounce span starts nothing
        @(negedge ref_clk);
        press(DEB - 2);
        repeat (30) @(negedge ref_clk);
        chk_flag(busy, 1'b0);
        // a fuse that will not open must be reported
        weak_bit = 8'h10;
        run_word(9'h055, 8'h11);
        chk_flag(verify_fail, 1'b1);
        chk_word(display, 8'hFE);
        // next accepted press clears the failure flag
        weak_bit = 8'h00;
        run_word(9'h055, 8'h00);
        chk_flag(verify_fail, 1'b0);
        chk_count(npulse, 0);
        // a second press while running is ignored
        @(negedge ref_clk);
        addr_switch = 9'h0F0;
        pattern_switch = 8'h08;
        npulse = 0;
        ndone = 0;
        press(DEB + 3);
        repeat (60) @(negedge ref_clk);
        chk_flag(busy, 1'b1);
        press(DEB + 3);
        repeat (1500) @(negedge ref_clk);
        chk_count(ndone, 1);
        chk_count(npulse, 1);
        chk_word(display, 8'hF7);
        end_sim();
    end
endmodule : prom_fuse_programmer_bench
`default_nettype wire
